// file: bench/host_model.sv
//
// Purpose : host processor model on the internal register port
// Assumes : requests start and end at rising edges
// Notes   : read data is taken at the edge after the strobe is lowered
//
`timescale 1ns/1ps
module host_model
	import qmu_ctl_pkg::*;
(
	// clock and link state
	input  wire logic        core_clk,
	input  wire logic        full_duplex,
	// register port
	output logic [15:0]      reg_addr,
	output logic             reg_wr_en,
	output logic             reg_rd_en,
	output logic [1:0]       reg_be,
	output logic [15:0]      reg_wdata,
	input  wire logic [15:0] reg_rdata,
	input  wire logic        reg_rvalid
);
	// ****************************************************
	// bus cycles
	// ****************************************************
	// idle bus at time zero
	initial begin
		reg_addr  = 16'h0000;
		reg_wr_en = 1'b0;
		reg_rd_en = 1'b0;
		reg_be    = 2'h0;
		reg_wdata = 16'h0000;
	end

	// one write, data inverted after release so stale data never looks valid
	task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic [1:0] be);
		@(posedge core_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_be    <= be;
		reg_wr_en <= 1'b1;
		@(posedge core_clk);
		reg_wr_en <= 1'b0;
		reg_wdata <= ~d;
	endtask : wr

	// one read, answer taken the cycle after the strobe
	task automatic rd(input logic [15:0] a, output logic [15:0] d, output logic v);
		@(posedge core_clk);
		reg_addr  <= a;
		reg_rd_en <= 1'b1;
		@(posedge core_clk);
		reg_rd_en <= 1'b0;
		@(posedge core_clk);
		d = reg_rdata;
		v = reg_rvalid;
	endtask : rd

	// pause honour kept off in half duplex, where it means nothing
	task automatic wr_ctrl(input logic [15:0] d);
		logic [15:0] v;
		v = d;
		if (!full_duplex) begin
			v[RC_PAUSE] = 1'b0;
		end
		wr(RX_CTRL_OFF, v, 2'h3);
	endtask : wr_ctrl

	// receive stopped before the flush bit goes up
	task automatic flush(input logic [15:0] d);
		wr_ctrl(d & 16'hfffe);
		wr_ctrl((d & 16'hfffe) | 16'h8000);
	endtask : flush

endmodule : host_model

// file: bench/qmu_txstat_rxctl_test.sv
//
// Purpose : self-checking bench for the status word and receive control word
// Assumes : 20 MHz core clock, all mac side strobes on that clock
// Notes   : expectations come from the bit map, never from the design
//
`timescale 1ns/1ps
`define CHK(a, e, m) begin total_checks++; if ((a) !== (e)) begin n_fail++; $display("MISMATCH t=%0t %s", $time, m); end end
module qmu_txstat_rxctl_test;
	import qmu_ctl_pkg::*;
	localparam logic [MAC_W-1:0] STA = 48'h0200_0000_0001;
	localparam logic [MAC_W-1:0] OTH = 48'h0200_0000_0099;
	localparam logic [MAC_W-1:0] MC  = 48'h0100_5e00_0001;
	// ****************************************************
	// signals
	// ****************************************************
	logic                core_clk = 1'b0, nrst = 1'b0, full_duplex = 1'b1;
	logic                tx_done = 1'b0, tx_late_col = 1'b0, tx_max_col = 1'b0;
	logic [TAG_W-1:0]    tx_done_tag = 6'h00;
	logic                rx_sof = 1'b0, rx_eof = 1'b0, rx_hash_hit = 1'b0;
	logic                rx_is_pause = 1'b0, quanta_tick = 1'b0;
	logic [6:0]          rx_attr = 7'h00;
	logic [MAC_W-1:0]    rx_dest_addr = 48'h0;
	logic [QUANTA_W-1:0] rx_pause_quanta = 16'h0000;
	logic [15:0]         reg_addr, reg_wdata, reg_rdata, rdv;
	logic [1:0]          reg_be;
	logic                reg_wr_en, reg_rd_en, reg_rvalid, rvl;
	logic                frame_store, frame_drop, rx_active, rxq_clear, tx_hold;
	int                  n_fail = 0;
	int                  total_checks = 0;

	always #25 core_clk = ~core_clk;

	host_model host_model_inst (.core_clk, .full_duplex, .reg_addr, .reg_wr_en, .reg_rd_en,
		.reg_be, .reg_wdata, .reg_rdata, .reg_rvalid);

	qmu_txstat_rxctl qmu_txstat_rxctl_inst (.core_clk, .nrst, .reg_addr, .reg_wr_en,
		.reg_rd_en, .reg_be, .reg_wdata, .reg_rdata, .reg_rvalid, .tx_done, .tx_done_tag,
		.tx_late_col, .tx_max_col, .rx_sof, .rx_eof, .rx_dest_addr, .rx_hash_hit,
		.rx_is_ip(rx_attr[6]), .rx_ip_ok(rx_attr[5]), .rx_is_tcp(rx_attr[4]),
		.rx_tcp_ok(rx_attr[3]), .rx_is_udp(rx_attr[2]), .rx_udp_ok(rx_attr[1]),
		.rx_crc_err(rx_attr[0]), .rx_is_pause, .rx_pause_quanta, .station_addr(STA),
		.full_duplex, .quanta_tick, .frame_store, .frame_drop, .rx_active, .rxq_clear,
		.tx_hold);

	// ****************************************************
	// helpers
	// ****************************************************
	task automatic chk_rd(input logic [15:0] a, input logic [15:0] e);
		host_model_inst.rd(a, rdv, rvl);
		`CHK(rdv, e, "read data")
		`CHK(rvl, 1'b1, "read valid")
	endtask : chk_rd

	// one frame: sof, eof with attributes one cycle later, verdict the cycle after
	task automatic send(input logic [MAC_W-1:0] da, input logic hh, input logic [6:0] at,
		input logic [15:0] pq);
		@(posedge core_clk) rx_sof <= 1'b1;
		@(posedge core_clk) rx_sof <= 1'b0;
		rx_eof          <= 1'b1;
		rx_dest_addr    <= da;
		rx_hash_hit     <= hh;
		rx_attr         <= at;
		rx_is_pause     <= (pq != 16'h0000);
		rx_pause_quanta <= pq;
		@(posedge core_clk) rx_eof <= 1'b0;
		@(posedge core_clk);
	endtask : send

	task automatic frame(input logic [15:0] c, input logic [MAC_W-1:0] da, input logic hh,
		input logic [6:0] at, input logic e);
		host_model_inst.wr_ctrl(c);
		send(da, hh, at, 16'h0000);
		`CHK(frame_store, e, "frame store")
		`CHK(frame_drop, !e, "frame drop")
	endtask : frame

	task automatic tick(input int n);
		repeat (n) begin
			@(posedge core_clk) quanta_tick <= 1'b1;
			@(posedge core_clk) quanta_tick <= 1'b0;
		end
	endtask : tick

	// ****************************************************
	// scenarios
	// ****************************************************
	task automatic t_reset();
		chk_rd(RX_CTRL_OFF, RX_CTRL_RESET);
		chk_rd(TX_STATUS_OFF, 16'h0000);
		chk_rd(16'h0180, 16'h0000);
	endtask : t_reset

	task automatic t_status();
		@(posedge core_clk) {tx_done, tx_done_tag, tx_late_col, tx_max_col} <= {1'b1, 6'h2a, 2'b10};
		@(posedge core_clk) tx_done <= 1'b0;
		chk_rd(TX_STATUS_OFF, 16'h202a);
		// back to back: only the later frame may remain
		@(posedge core_clk) {tx_done, tx_done_tag, tx_late_col, tx_max_col} <= {1'b1, 6'h3f, 2'b11};
		@(posedge core_clk) {tx_done, tx_done_tag, tx_late_col, tx_max_col} <= {1'b1, 6'h15, 2'b01};
		@(posedge core_clk) tx_done <= 1'b0;
		chk_rd(TX_STATUS_OFF, 16'h1015);
		host_model_inst.wr(TX_STATUS_OFF, 16'hffff, 2'h3);
		chk_rd(TX_STATUS_OFF, 16'h1015);
	endtask : t_status

	task automatic t_regs();
		host_model_inst.wr(RX_CTRL_OFF, 16'hffff, 2'h3);
		chk_rd(16'h0175, 16'hfff3);
		host_model_inst.wr(RX_CTRL_OFF, 16'h0000, 2'h1);
		chk_rd(RX_CTRL_OFF, 16'hff00);
	endtask : t_regs

	task automatic t_filter();
		frame(16'h0021, STA, 1'b0, 7'h00, 1'b1);
		frame(16'h0021, OTH, 1'b1, 7'h00, 1'b0);
		frame(16'h0023, OTH, 1'b0, 7'h00, 1'b1);
		frame(16'h0023, STA, 1'b0, 7'h00, 1'b0);
		frame(16'h0801, STA, 1'b1, 7'h00, 1'b1);
		frame(16'h0801, STA, 1'b0, 7'h00, 1'b0);
		frame(16'h0081, BCAST_ADDR, 1'b0, 7'h00, 1'b1);
		frame(16'h0081, MC, 1'b1, 7'h00, 1'b0);
		frame(16'h0041, MC, 1'b0, 7'h00, 1'b1);
		frame(16'h0041, BCAST_ADDR, 1'b0, 7'h00, 1'b1);
		frame(16'h0101, MC, 1'b1, 7'h00, 1'b1);
		frame(16'h0101, MC, 1'b0, 7'h00, 1'b0);
		frame(16'h0011, OTH, 1'b0, 7'h00, 1'b1);
		frame(16'h1011, OTH, 1'b0, 7'h40, 1'b0);
		frame(16'h1011, OTH, 1'b0, 7'h60, 1'b1);
		frame(16'h2011, OTH, 1'b0, 7'h10, 1'b0);
		frame(16'h0011, OTH, 1'b0, 7'h10, 1'b1);
		frame(16'h4011, OTH, 1'b0, 7'h04, 1'b0);
		frame(16'h4011, OTH, 1'b0, 7'h06, 1'b1);
		frame(16'h0011, OTH, 1'b0, 7'h01, 1'b0);
		frame(16'h0211, OTH, 1'b0, 7'h01, 1'b1);
	endtask : t_filter

	// enable cleared inside a frame: that frame still completes
	task automatic t_stop();
		frame(16'h0011, OTH, 1'b0, 7'h00, 1'b1);
		@(posedge core_clk) rx_sof <= 1'b1;
		@(posedge core_clk) rx_sof <= 1'b0;
		host_model_inst.wr_ctrl(16'h0010);
		repeat (2) @(posedge core_clk);
		`CHK(rx_active, 1'b1, "stopped mid frame")
		@(posedge core_clk) rx_eof <= 1'b1;
		@(posedge core_clk) rx_eof <= 1'b0;
		@(posedge core_clk);
		`CHK(frame_store, 1'b1, "open frame lost")
		@(posedge core_clk);
		`CHK(rx_active, 1'b0, "still running")
		send(OTH, 1'b0, 7'h00, 16'h0000);
		`CHK(frame_store | frame_drop, 1'b0, "frame while stopped")
	endtask : t_stop

	// a frame still open when the flush lands is never reported
	task automatic t_flush();
		host_model_inst.wr_ctrl(16'h0011);
		repeat (2) @(posedge core_clk);
		@(posedge core_clk) rx_sof <= 1'b1;
		@(posedge core_clk) rx_sof <= 1'b0;
		host_model_inst.flush(16'h0011);
		rx_eof <= 1'b1;
		@(posedge core_clk) rx_eof <= 1'b0;
		@(posedge core_clk);
		`CHK(frame_store | frame_drop, 1'b0, "flushed frame reported")
		`CHK(rxq_clear, 1'b1, "flush not in force")
		host_model_inst.wr_ctrl(16'h0010);
		repeat (2) @(posedge core_clk);
		`CHK(rxq_clear, 1'b0, "flush stuck")
	endtask : t_flush

	task automatic t_pause();
		host_model_inst.wr_ctrl(16'h0411);
		repeat (2) @(posedge core_clk);
		send(OTH, 1'b0, 7'h00, 16'h0003);
		`CHK(tx_hold, 1'b1, "pause not honoured")
		tick(2);
		`CHK(tx_hold, 1'b1, "pause ended early")
		tick(1);
		repeat (2) @(posedge core_clk);
		`CHK(tx_hold, 1'b0, "pause never ends")
		// link drops to half duplex with the bit still on: pause ignored
		full_duplex <= 1'b0;
		send(OTH, 1'b0, 7'h00, 16'h0003);
		`CHK(tx_hold, 1'b0, "pause honoured in half duplex")
	endtask : t_pause

	// ****************************************************
	// run control
	// ****************************************************
	task automatic final_report();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : final_report

	initial begin
		repeat (12) @(posedge core_clk);
		nrst <= 1'b1;
		@(posedge core_clk);
		t_reset();
		t_status();
		t_regs();
		t_filter();
		t_stop();
		t_flush();
		t_pause();
		final_report();
	end

	// whole run needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge core_clk);
		n_fail++;
		final_report();
	end

endmodule : qmu_txstat_rxctl_test

// file: rtl/dest_addr_check.sv
//
// Purpose : destination address acceptance for one received frame
// Assumes : address and hash hit are stable while the frame ends
// Notes   : purely combinational, the caller registers the verdict
//
`timescale 1ns/1ps
module dest_addr_check
	import qmu_ctl_pkg::*;
(
	// frame address
	input  wire logic [MAC_W-1:0] dest_addr,
	input  wire logic             hash_hit,
	input  wire logic [MAC_W-1:0] station_addr,
	// mode bits
	input  wire logic [15:0]      ctrl,
	// verdict
	output logic                  addr_pass
);

	// ****************************************************
	// address class and match
	// ****************************************************
	logic is_bcast;
	logic is_mcast;
	logic own_match;

	// group bit is the first bit on the wire, lsb of the first octet
	always_comb begin
		is_bcast  = dest_addr == BCAST_ADDR;
		is_mcast  = dest_addr[GROUP_BIT];
		// inverse mode turns the station comparison around
		own_match = (dest_addr == station_addr) ^ ctrl[RC_INV];  // RL18
		addr_pass = ctrl[RC_ALL]                                   // RL17
			| (is_bcast & ctrl[RC_BCAST])                          // RL14
			| (is_mcast & ctrl[RC_MCAST])                          // RL15
			| (is_mcast & !is_bcast & ctrl[RC_MCFILT] & hash_hit)  // RL13
			| (!is_mcast & ctrl[RC_UCAST] & own_match)             // RL16
			| (!is_mcast & ctrl[RC_PHYS] & own_match & hash_hit);  // RL10
	end

endmodule : dest_addr_check

// file: rtl/pause_hold.sv
//
// Purpose : hold transmission while a received pause is in force
// Assumes : quanta_tick pulses once per pause quantum of link time
// Notes   : a new pause frame reloads the timer, zero quanta releases at once
//
`timescale 1ns/1ps
module pause_hold
	import qmu_ctl_pkg::*;
(
	// clock and reset
	input  wire logic                core_clk,
	input  wire logic                nrst,
	// pause request
	input  wire logic                load,
	input  wire logic [QUANTA_W-1:0] quanta,
	input  wire logic                quanta_tick,
	// hold out
	output logic                     tx_hold
);

	// ****************************************************
	// pause timer
	// ****************************************************
	logic [QUANTA_W-1:0] count_ff;
	logic [QUANTA_W-1:0] nxt_count;
	logic                hold_ff;
	logic                nxt_hold;

	// reload wins over the countdown so a fresh pause is never lost
	always_comb begin
		nxt_count = count_ff;
		if (load) begin
			nxt_count = quanta;
		end else if (quanta_tick && count_ff != '0) begin
			nxt_count = count_ff - 1'b1;
		end
		nxt_hold = nxt_count != '0;  // RL11
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			count_ff <= '0;
			hold_ff  <= 1'b0;
		end else begin
			count_ff <= nxt_count;
			hold_ff  <= nxt_hold;
		end
	end

	assign tx_hold = hold_ff;

	pause_load_a: assert property (@(posedge core_clk) disable iff (!nrst)  // RL11
		load && quanta != '0 |=> tx_hold && count_ff == $past(quanta))
		else $error("pause load did not hold transmit");

endmodule : pause_hold

// file: rtl/qmu_ctl_pkg.sv
//
// Purpose : constants for the queue manager transmit status and receive control word
// Assumes : 16-bit internal register space, byte addressed
// Notes   : all field positions and offsets live here
//
package qmu_ctl_pkg;

	// ****************************************************
	// register map
	// ****************************************************
	localparam logic [15:0] TX_STATUS_OFF  = 16'h0172;
	localparam logic [15:0] RX_CTRL_OFF    = 16'h0174;
	localparam logic [15:0] RX_CTRL_RESET  = 16'h0800;  // physical address filter on
	localparam logic [15:0] RX_CTRL_WMASK  = 16'hfff3;  // bits 3..2 reserved
	localparam logic [15:0] TX_STATUS_MASK = 16'h303f;  // defined bits only

	// ****************************************************
	// transmit status fields
	// ****************************************************
	localparam int TAG_W      = 6;
	localparam int TS_LATE    = 13;
	localparam int TS_MAXCOL  = 12;

	// ****************************************************
	// receive control fields
	// ****************************************************
	localparam int RC_FLUSH   = 15;
	localparam int RC_UDP     = 14;
	localparam int RC_TCP     = 13;
	localparam int RC_IP      = 12;
	localparam int RC_PHYS    = 11;
	localparam int RC_PAUSE   = 10;
	localparam int RC_CRCACC  = 9;
	localparam int RC_MCFILT  = 8;
	localparam int RC_BCAST   = 7;
	localparam int RC_MCAST   = 6;
	localparam int RC_UCAST   = 5;
	localparam int RC_ALL     = 4;
	localparam int RC_INV     = 1;
	localparam int RC_RUN     = 0;

	// ****************************************************
	// addressing and pause
	// ****************************************************
	localparam int MAC_W      = 48;
	localparam int QUANTA_W   = 16;
	localparam logic [MAC_W-1:0] BCAST_ADDR = 48'hffff_ffff_ffff;
	localparam int GROUP_BIT  = 40;  // lsb of the first octet on the wire

	// match of a byte address against either byte of a register's word
	function automatic logic reg_hit(input logic [15:0] addr, input logic [15:0] off);
		return addr[15:1] == off[15:1];
	endfunction : reg_hit

endpackage : qmu_ctl_pkg

// file: rtl/qmu_txstat_rxctl.sv
//
// Purpose : transmit status word and first receive control word of the queue manager
// Assumes : mac side strobes are on core_clk; host port is the internal register port
// Notes   : read data is registered and appears one cycle after the read strobe
//
// Summary of operation
// RL1: late collision during a frame sets status bit 13.
// RL2: reaching the collision limit sets status bit 12.
// RL3: status bits 5..0 carry the frame tag; all flags describe that frame.
// RL4: status word at 0x172 holds the latest frame and is read-only.
// RL5: while flush bit 15 is set, clear the receive queue and frame pointer.
// RL6: host clears receive enable before flushing, then clears flush again.
// RL7: with bit 14 set, drop UDP frames with a bad UDP checksum.
// RL8: with bit 13 set, drop TCP frames with a bad TCP checksum.
// RL9: with bit 12 set, drop IP frames with a bad header checksum.
// RL10: bit 11, default one, accepts unicast passing the address filter.
// RL11: bit 10 in full duplex honours pause; host keeps it zero in half duplex.
// RL12: bit 9 stores frames with CRC errors; clear discards them all.
// RL13: bit 8 accepts multicast frames passing the address filter.
// RL14: bit 7 accepts every broadcast frame.
// RL15: bit 6 accepts every multicast frame, broadcast included.
// RL16: bit 5 accepts unicast matching the 48-bit station address.
// RL17: bit 4 accepts every frame whatever its destination.
// RL18: bit 1 turns the address check into inverse filtering.
// RL19: bit 0 runs reception; clearing stops after the current frame.
// RL20: reserved status bits read zero; writes to reserved bits do nothing.
//
`timescale 1ns/1ps
module qmu_txstat_rxctl
	import qmu_ctl_pkg::*;
(
	// clock and reset
	input  wire logic                core_clk,
	input  wire logic                nrst,
	// host register port
	input  wire logic [15:0]         reg_addr,
	input  wire logic                reg_wr_en,
	input  wire logic                reg_rd_en,
	input  wire logic [1:0]          reg_be,
	input  wire logic [15:0]         reg_wdata,
	output logic [15:0]              reg_rdata,
	output logic                     reg_rvalid,
	// transmit result from the mac
	input  wire logic                tx_done,
	input  wire logic [TAG_W-1:0]    tx_done_tag,
	input  wire logic                tx_late_col,
	input  wire logic                tx_max_col,
	// received frame from the mac
	input  wire logic                rx_sof,
	input  wire logic                rx_eof,
	input  wire logic [MAC_W-1:0]    rx_dest_addr,
	input  wire logic                rx_hash_hit,
	input  wire logic                rx_is_ip,
	input  wire logic                rx_ip_ok,
	input  wire logic                rx_is_tcp,
	input  wire logic                rx_tcp_ok,
	input  wire logic                rx_is_udp,
	input  wire logic                rx_udp_ok,
	input  wire logic                rx_crc_err,
	input  wire logic                rx_is_pause,
	input  wire logic [QUANTA_W-1:0] rx_pause_quanta,
	// link state
	input  wire logic [MAC_W-1:0]    station_addr,
	input  wire logic                full_duplex,
	input  wire logic                quanta_tick,
	// queue side
	output logic                     frame_store,
	output logic                     frame_drop,
	output logic                     rx_active,
	output logic                     rxq_clear,
	output logic                     tx_hold
);

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);

	// ****************************************************
	// register state
	// ****************************************************
	logic [15:0] tx_stat_ff;
	logic [15:0] nxt_tx_stat;
	logic [15:0] rx_ctrl_ff;
	logic [15:0] nxt_rx_ctrl;
	logic [15:0] rdata_ff;
	logic [15:0] nxt_rdata;
	logic        rvalid_ff;
	logic        nxt_rvalid;
	logic [15:0] be_mask;

	// status reloads whole on each finished frame, so flags never mix frames
	always_comb begin
		be_mask     = {{8{reg_be[1]}}, {8{reg_be[0]}}};
		nxt_tx_stat = tx_stat_ff;
		if (tx_done) begin
			nxt_tx_stat = '0;                               // RL20
			nxt_tx_stat[TAG_W-1:0] = tx_done_tag;           // RL3
			nxt_tx_stat[TS_LATE]   = tx_late_col;           // RL1
			nxt_tx_stat[TS_MAXCOL] = tx_max_col;            // RL2
		end
		nxt_rx_ctrl = rx_ctrl_ff;
		if (reg_wr_en && reg_hit(reg_addr, RX_CTRL_OFF)) begin
			// reserved positions keep their reset zero
			nxt_rx_ctrl = (rx_ctrl_ff & ~(be_mask & RX_CTRL_WMASK))
				| (reg_wdata & be_mask & RX_CTRL_WMASK);       // RL20
		end
		// host writes to the status word are ignored
		nxt_rvalid = reg_rd_en;
		nxt_rdata  = '0;
		if (reg_rd_en && reg_hit(reg_addr, TX_STATUS_OFF)) begin
			nxt_rdata = tx_stat_ff & TX_STATUS_MASK;        // RL4
		end else if (reg_rd_en && reg_hit(reg_addr, RX_CTRL_OFF)) begin
			nxt_rdata = rx_ctrl_ff;
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			tx_stat_ff <= '0;
			rx_ctrl_ff <= RX_CTRL_RESET;
			rdata_ff   <= '0;
			rvalid_ff  <= 1'b0;
		end else begin
			tx_stat_ff <= nxt_tx_stat;
			rx_ctrl_ff <= nxt_rx_ctrl;
			rdata_ff   <= nxt_rdata;
			rvalid_ff  <= nxt_rvalid;
		end
	end

	assign reg_rdata  = rdata_ff;
	assign reg_rvalid = rvalid_ff;

	// ****************************************************
	// frame admission
	// ****************************************************
	logic addr_pass;

	dest_addr_check dest_addr_check_inst (
		.dest_addr    (rx_dest_addr),
		.hash_hit     (rx_hash_hit),
		.station_addr (station_addr),
		.ctrl         (rx_ctrl_ff),
		.addr_pass    (addr_pass)
	);

	logic in_frame_ff;
	logic nxt_in_frame;
	logic active_ff;
	logic nxt_active;
	logic store_ff;
	logic nxt_store;
	logic drop_ff;
	logic nxt_drop;
	logic clear_ff;
	logic nxt_clear;
	logic cksum_bad;
	logic crc_bad;
	logic frame_end;
	logic pause_load;

	// a frame counts only if it started while reception was running
	always_comb begin
		frame_end    = rx_eof && in_frame_ff && !rx_ctrl_ff[RC_FLUSH];  // RL5
		nxt_in_frame = in_frame_ff;
		if (rx_sof && active_ff && !rx_ctrl_ff[RC_FLUSH]) begin
			nxt_in_frame = 1'b1;
		end else if (rx_eof || rx_ctrl_ff[RC_FLUSH]) begin
			nxt_in_frame = 1'b0;
		end
		// stop is deferred while a frame is still arriving
		nxt_active = rx_ctrl_ff[RC_RUN] || (active_ff && nxt_in_frame);  // RL19
		cksum_bad = (rx_ctrl_ff[RC_UDP] && rx_is_udp && !rx_udp_ok)    // RL7
			|| (rx_ctrl_ff[RC_TCP] && rx_is_tcp && !rx_tcp_ok)          // RL8
			|| (rx_ctrl_ff[RC_IP] && rx_is_ip && !rx_ip_ok);            // RL9
		crc_bad   = rx_crc_err && !rx_ctrl_ff[RC_CRCACC];               // RL12
		nxt_store = frame_end && addr_pass && !cksum_bad && !crc_bad;
		nxt_drop  = frame_end && !nxt_store;
		// a flush empties the queue and rewinds the frame pointer
		nxt_clear = rx_ctrl_ff[RC_FLUSH];                               // RL5
		// pause is a half duplex no-op even if the host left the bit set
		pause_load = frame_end && rx_is_pause && !rx_crc_err
			&& rx_ctrl_ff[RC_PAUSE] && full_duplex;                     // RL11
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			in_frame_ff <= 1'b0;
			active_ff   <= 1'b0;
			store_ff    <= 1'b0;
			drop_ff     <= 1'b0;
			clear_ff    <= 1'b0;
		end else begin
			in_frame_ff <= nxt_in_frame;
			active_ff   <= nxt_active;
			store_ff    <= nxt_store;
			drop_ff     <= nxt_drop;
			clear_ff    <= nxt_clear;
		end
	end

	assign frame_store = store_ff;
	assign frame_drop  = drop_ff;
	assign rx_active   = active_ff;
	assign rxq_clear   = clear_ff;

	// ****************************************************
	// pause honouring
	// ****************************************************
	pause_hold pause_hold_inst (
		.core_clk    (core_clk),
		.nrst        (nrst),
		.load        (pause_load),
		.quanta      (rx_pause_quanta),
		.quanta_tick (quanta_tick),
		.tx_hold     (tx_hold)
	);

	// ****************************************************
	// checks
	// ****************************************************
	late_flag_a: assert property (tx_done |=> tx_stat_ff[TS_LATE] == $past(tx_late_col))  // RL1
		else $error("late collision flag wrong");
	max_flag_a: assert property (tx_done |=> tx_stat_ff[TS_MAXCOL] == $past(tx_max_col))  // RL2
		else $error("max collision flag wrong");
	frame_tag_a: assert property (tx_done ##1 !tx_done |=> $stable(tx_stat_ff[TAG_W-1:0]))  // RL3
		else $error("frame tag changed without a new frame");
	status_read_a: assert property (reg_rd_en && reg_hit(reg_addr, TX_STATUS_OFF)  // RL4
		&& !tx_done |=> reg_rvalid && reg_rdata == (tx_stat_ff & TX_STATUS_MASK))
		else $error("status read mismatch");
	reserved_zero_a: assert property (reg_rvalid  // RL20
		|-> (reg_rdata & ~($past(reg_hit(reg_addr, TX_STATUS_OFF))
		? TX_STATUS_MASK : RX_CTRL_WMASK)) == 16'h0000)
		else $error("reserved bits read nonzero");
	flush_clear_a: assert property (rx_ctrl_ff[RC_FLUSH] |=> rxq_clear && !in_frame_ff)  // RL5
		else $error("flush did not clear the queue");
	udp_drop_a: assert property (frame_end && rx_ctrl_ff[RC_UDP] && rx_is_udp  // RL7
		&& !rx_udp_ok |=> frame_drop && !frame_store)
		else $error("bad udp frame stored");
	tcp_drop_a: assert property (frame_end && rx_ctrl_ff[RC_TCP] && rx_is_tcp  // RL8
		&& !rx_tcp_ok |=> frame_drop)
		else $error("bad tcp frame stored");
	ip_drop_a: assert property (frame_end && rx_ctrl_ff[RC_IP] && rx_is_ip  // RL9
		&& !rx_ip_ok |=> frame_drop)
		else $error("bad ip frame stored");
	crc_drop_a: assert property (frame_end && rx_crc_err && !rx_ctrl_ff[RC_CRCACC]  // RL12
		|=> frame_drop)
		else $error("crc error frame stored");
	all_accept_a: assert property (frame_end && rx_ctrl_ff[RC_ALL] && !cksum_bad  // RL17
		&& !crc_bad |=> frame_store)
		else $error("receive all frame dropped");
	bcast_accept_a: assert property (frame_end && rx_ctrl_ff[RC_BCAST]  // RL14
		&& rx_dest_addr == BCAST_ADDR && !cksum_bad && !crc_bad |=> frame_store)
		else $error("broadcast frame dropped");
	stop_defer_a: assert property (in_frame_ff && active_ff && !rx_eof  // RL19
		&& !rx_ctrl_ff[RC_FLUSH] |=> rx_active)
		else $error("reception stopped mid frame");
	// run and flush bits act on the next edge
	stop_done_a: assert property (frame_end && !rx_sof && !rx_ctrl_ff[RC_RUN]  // RL19
		|=> !rx_active)
		else $error("reception ran past the last frame");
	rx_start_a: assert property (rx_ctrl_ff[RC_RUN] |=> rx_active)  // RL19
		else $error("reception did not start");
	flush_abort_a: assert property (rx_ctrl_ff[RC_FLUSH] && rx_eof  // RL5
		|=> !frame_store && !frame_drop)
		else $error("frame reported during flush");
	crc_keep_a: assert property (frame_end && rx_crc_err && rx_ctrl_ff[RC_CRCACC]  // RL12
		&& rx_ctrl_ff[RC_ALL] && !cksum_bad |=> frame_store)
		else $error("crc error frame lost");
	pause_duplex_a: assert property (frame_end && rx_is_pause && !full_duplex  // RL11
		&& !tx_hold |=> !tx_hold)
		else $error("pause honoured in half duplex");
	// the status word only moves on a finished frame
	status_write_a: assert property (reg_wr_en && reg_hit(reg_addr, TX_STATUS_OFF)  // RL4
		&& !tx_done |=> $stable(tx_stat_ff))
		else $error("host write changed the status word");
	// reserved control bits stay clear whatever the host writes
	ctrl_write_a: assert property (reg_wr_en && reg_hit(reg_addr, RX_CTRL_OFF)  // RL20
		|=> (rx_ctrl_ff & ~RX_CTRL_WMASK) == 16'h0000)
		else $error("reserved control bit took a write");

	// ****************************************************
	// address filter checks
	// ****************************************************
	// one mode alone keeps a clean frame of its class
	ucast_accept_a: assert property (frame_end && rx_ctrl_ff[RC_UCAST]  // RL16
		&& !rx_ctrl_ff[RC_INV] && rx_dest_addr == station_addr && !station_addr[GROUP_BIT]
		&& !cksum_bad && !crc_bad |=> frame_store)
		else $error("own unicast frame dropped");
	inv_filter_a: assert property (frame_end && rx_ctrl_ff[RC_UCAST]  // RL18
		&& rx_ctrl_ff[RC_INV] && !rx_dest_addr[GROUP_BIT] && rx_dest_addr != station_addr
		&& !cksum_bad && !crc_bad |=> frame_store)
		else $error("inverse filter dropped a foreign frame");
	phys_filter_a: assert property (frame_end && rx_ctrl_ff[RC_PHYS] && rx_hash_hit  // RL10
		&& !rx_ctrl_ff[RC_INV] && rx_dest_addr == station_addr && !station_addr[GROUP_BIT]
		&& !cksum_bad && !crc_bad |=> frame_store)
		else $error("filtered unicast frame dropped");
	mcast_accept_a: assert property (frame_end && rx_ctrl_ff[RC_MCAST]  // RL15
		&& rx_dest_addr[GROUP_BIT] && !cksum_bad && !crc_bad |=> frame_store)
		else $error("multicast frame dropped");
	mcast_filter_a: assert property (frame_end && rx_ctrl_ff[RC_MCFILT]  // RL13
		&& rx_hash_hit && rx_dest_addr[GROUP_BIT] && rx_dest_addr != BCAST_ADDR
		&& !cksum_bad && !crc_bad |=> frame_store)
		else $error("filtered multicast frame dropped");

endmodule : qmu_txstat_rxctl
